// ===== iqc_pkg.sv
// Purpose: constants and types for the ingress qos classifier
// Assumes: 12 switch ports, apb register access, 32-bit data
// Notes: one 64-byte register window per port
package iqc_pkg;
    localparam int NUM_PORTS = 12;
    localparam int PORT_W = 4;
    localparam int CFG_W = 17;
    localparam int MAP_W = 64;
    localparam int NIB_W = 4;
    // address split: port in [9:6], word in [5:2]
    localparam int PORT_LSB = 6;
    localparam int OFS_W = 6;
    localparam logic [5:0] OFS_CFG = 6'h00;
    localparam logic [5:0] OFS_EFF = 6'h04;
    localparam logic [5:0] OFS_TMAP_LO = 6'h08;
    localparam logic [5:0] OFS_TMAP_HI = 6'h0C;
    localparam logic [5:0] OFS_EMAP_LO = 6'h10;
    localparam logic [5:0] OFS_EMAP_HI = 6'h14;
    localparam int EFF_CFG_LSB = 8;
    // egress tag remark modes
    localparam logic [1:0] RMK_CLASSIFIED = 2'h0;
    localparam logic [1:0] RMK_DEFAULT = 2'h1;
    localparam logic [1:0] RMK_MAPPED = 2'h2;
    // ingress code point classify modes
    localparam logic [1:0] CLS_NONE = 2'h0;
    localparam logic [1:0] CLS_ZERO = 2'h1;
    localparam logic [1:0] CLS_SELECTED = 2'h2;
    localparam logic [1:0] CLS_ALL = 2'h3;
    // egress code point rewrite modes
    localparam logic [1:0] RW_DISABLE = 2'h0;
    localparam logic [1:0] RW_ENABLE = 2'h1;
    localparam logic [1:0] RW_REMAP = 2'h2;
    localparam logic [1:0] RW_REMAP_DP = 2'h3;
    // remap table select output
    localparam logic [1:0] REMAP_NONE = 2'h0;
    localparam logic [1:0] REMAP_DP0 = 2'h1;
    localparam logic [1:0] REMAP_DP1 = 2'h2;
    // pcp values that swap class order
    localparam logic [2:0] PCP_ZERO = 3'h0;
    localparam logic [2:0] PCP_ONE = 3'h1;
    localparam logic [2:0] CLASS_OF_PCP0 = 3'h1;
    localparam logic [2:0] CLASS_OF_PCP1 = 3'h0;
    localparam logic [5:0] DSCP_ZERO = 6'h00;
    localparam int TOS_DSCP_LSB = 2;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic vlan_aware;
        logic [1:0] rw_mode;
        logic [1:0] cls_mode;
        logic [1:0] rmk_mode;
        logic cp_classify_enable;
        logic tag_map_en;
        logic def_dei;
        logic [2:0] def_pcp;
        logic def_dp;
        logic [2:0] def_class;
    } iqc_cfg_type;
endpackage

// ===== iqc_classifier.sv
// Purpose: per-port ingress qos classification and egress tag remarking
// Assumes: inputs synchronous to clk, apb3 slave with one wait state
// Notes: results appear one cycle after the request strobe
// Operation
// - every frame gets one 3-bit qos class, class 0 being lowest.
// - tagged frames on aware ports without tag mapping map pcp 0->1, 1->0.
// - tag mapping looks up class and drop level by tag pcp and dei.
// - untagged frames and unaware ports use the port defaults.
// - without tag mapping a tagged frame's drop level on an aware port equals its dei.
// - classified pcp is the tag pcp when tagged on aware port, else default.
// - classified dei is the tag dei when tagged on aware port, else default.
// - a classification list hit overrides class and drop level last.
// - configured and effective default class are held apart and readable.
// - egress remark uses classified or default pcp and dei by mode.
// - mapped remark maps class and drop level through a port table.
// - each port has an enable for code point classification.
// - the code point is the upper six bits of the ip tos byte.
// - code point classify mode is none, zero only, selected or all.
// - egress code point rewrite is off, on, remap, or remap by drop level.
`timescale 1ns/1ns
`default_nettype none
module iqc_classifier
    import iqc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ingress request
    input wire logic in_valid,
    input wire logic [3:0] in_port,
    input wire logic in_tagged,
    input wire logic [2:0] in_pcp,
    input wire logic in_dei,
    input wire logic in_is_ip,
    input wire logic [7:0] in_tos,
    input wire logic [5:0] in_dscp_xlated,
    input wire logic in_dscp_selected,
    input wire logic in_list_hit,
    input wire logic [2:0] in_list_class,
    input wire logic in_list_dp,
    // ingress result
    output logic out_valid,
    output logic [2:0] out_class,
    output logic out_dp,
    output logic [2:0] out_pcp,
    output logic out_dei,
    output logic [5:0] out_dscp,
    output logic out_dscp_classify,
    // egress request
    input wire logic eg_valid,
    input wire logic [3:0] eg_port,
    input wire logic [2:0] eg_class,
    input wire logic eg_dp,
    input wire logic [2:0] eg_pcp,
    input wire logic eg_dei,
    // egress result
    output logic eg_out_valid,
    output logic [2:0] eg_out_pcp,
    output logic eg_out_dei,
    output logic eg_out_rewrite,
    output logic [1:0] eg_out_remap
);
    typedef struct packed {
        iqc_cfg_type [NUM_PORTS-1:0] cfg;
        logic [NUM_PORTS-1:0][2:0] eff_class;
        logic [NUM_PORTS-1:0][MAP_W-1:0] tmap;
        logic [NUM_PORTS-1:0][MAP_W-1:0] emap;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic o_valid;
        logic [2:0] o_class;
        logic o_dp;
        logic [2:0] o_pcp;
        logic o_dei;
        logic [5:0] o_dscp;
        logic o_dscp_cls;
        logic e_valid;
        logic [2:0] e_pcp;
        logic e_dei;
        logic e_rewrite;
        logic [1:0] e_remap;
    } iqc_state_type;

    iqc_state_type s_q;
    iqc_state_type s_d;

    logic [PORT_W-1:0] ap;
    logic [OFS_W-1:0] ofs;
    logic bad;
    logic [PORT_W-1:0] ip;
    logic [PORT_W-1:0] ep;
    iqc_cfg_type ic;
    iqc_cfg_type ec;
    logic tag_ok;
    logic [NIB_W-1:0] tnib;
    logic [NIB_W-1:0] enib;
    logic [5:0] dscp;
    logic dscp_cond;

    always_comb begin
        s_d = s_q;
        ap = paddr[PORT_LSB +: PORT_W];
        ofs = paddr[OFS_W-1:0];
        // unmapped ports or words answer with an error
        bad = (ap >= PORT_W'(NUM_PORTS)) || (ofs > OFS_EMAP_HI) ||
            (ofs[1:0] != 2'h0) || (paddr[11:10] != 2'h0);
        // one wait state: answer in the cycle after the first access cycle
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = psel && penable && !s_q.pready && bad;
        s_d.prdata = RD_ZERO;
        if (psel && penable && !s_q.pready && !pwrite && !bad) begin
            unique case (ofs)
                OFS_CFG: s_d.prdata = 32'(s_q.cfg[ap]);
                OFS_EFF: s_d.prdata = 32'(s_q.eff_class[ap]) |
                    (32'(s_q.cfg[ap].def_class) << EFF_CFG_LSB);
                OFS_TMAP_LO: s_d.prdata = s_q.tmap[ap][31:0];
                OFS_TMAP_HI: s_d.prdata = s_q.tmap[ap][63:32];
                OFS_EMAP_LO: s_d.prdata = s_q.emap[ap][31:0];
                default: s_d.prdata = s_q.emap[ap][63:32];
            endcase
        end
        if (psel && penable && s_q.pready && pwrite && !bad) begin
            unique case (ofs)
                OFS_CFG: begin
                    s_d.cfg[ap] = iqc_cfg_type'(pwdata[CFG_W-1:0]);
                    s_d.eff_class[ap] = pwdata[2:0];
                end
                OFS_EFF: s_d.eff_class[ap] = pwdata[2:0];
                OFS_TMAP_LO: s_d.tmap[ap][31:0] = pwdata;
                OFS_TMAP_HI: s_d.tmap[ap][63:32] = pwdata;
                OFS_EMAP_LO: s_d.emap[ap][31:0] = pwdata;
                default: s_d.emap[ap][63:32] = pwdata;
            endcase
        end

        // out-of-range port falls back to port 0 rather than x
        ip = (in_port < PORT_W'(NUM_PORTS)) ? in_port : '0;
        ic = s_q.cfg[ip];
        tag_ok = ic.vlan_aware && in_tagged;
        // 16-entry map, index {pcp,dei}, nibble {dp,class}
        tnib = s_q.tmap[ip][{in_pcp, in_dei, 2'h0} +: NIB_W];
        s_d.o_valid = in_valid;
        if (tag_ok && ic.tag_map_en) begin
            s_d.o_class = tnib[2:0];
            s_d.o_dp = tnib[3];
        end else if (tag_ok) begin
            if (in_pcp == PCP_ZERO) begin
                s_d.o_class = CLASS_OF_PCP0;
            end else if (in_pcp == PCP_ONE) begin
                s_d.o_class = CLASS_OF_PCP1;
            end else begin
                s_d.o_class = in_pcp;
            end
            s_d.o_dp = in_dei;
        end else begin
            s_d.o_class = s_q.eff_class[ip];
            s_d.o_dp = ic.def_dp;
        end
        s_d.o_pcp = tag_ok ? in_pcp : ic.def_pcp;
        s_d.o_dei = tag_ok ? in_dei : ic.def_dei;
        dscp = in_tos[7:TOS_DSCP_LSB];
        s_d.o_dscp = dscp;
        unique case (ic.cls_mode)
            CLS_NONE: dscp_cond = 1'b0;
            CLS_ZERO: dscp_cond = (in_dscp_xlated == DSCP_ZERO);
            CLS_SELECTED: dscp_cond = in_dscp_selected;
            CLS_ALL: dscp_cond = 1'b1;
        endcase
        s_d.o_dscp_cls = ic.cp_classify_enable && in_is_ip && dscp_cond;
        if (in_list_hit) begin
            s_d.o_class = in_list_class;
            s_d.o_dp = in_list_dp;
        end

        ep = (eg_port < PORT_W'(NUM_PORTS)) ? eg_port : '0;
        ec = s_q.cfg[ep];
        // index {class,dp}, nibble {dei,pcp}
        enib = s_q.emap[ep][{eg_class, eg_dp, 2'h0} +: NIB_W];
        s_d.e_valid = eg_valid;
        unique case (ec.rmk_mode)
            RMK_DEFAULT: begin
                s_d.e_pcp = ec.def_pcp;
                s_d.e_dei = ec.def_dei;
            end
            RMK_MAPPED: begin
                s_d.e_pcp = enib[2:0];
                s_d.e_dei = enib[3];
            end
            // classified remark, also for the unused code
            default: begin
                s_d.e_pcp = eg_pcp;
                s_d.e_dei = eg_dei;
            end
        endcase
        s_d.e_rewrite = (ec.rw_mode != RW_DISABLE);
        unique case (ec.rw_mode)
            RW_REMAP: s_d.e_remap = REMAP_DP0;
            RW_REMAP_DP: s_d.e_remap = eg_dp ? REMAP_DP1 : REMAP_DP0;
            default: s_d.e_remap = REMAP_NONE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign out_valid = s_q.o_valid;
    assign out_class = s_q.o_class;
    assign out_dp = s_q.o_dp;
    assign out_pcp = s_q.o_pcp;
    assign out_dei = s_q.o_dei;
    assign out_dscp = s_q.o_dscp;
    assign out_dscp_classify = s_q.o_dscp_cls;
    assign eg_out_valid = s_q.e_valid;
    assign eg_out_pcp = s_q.e_pcp;
    assign eg_out_dei = s_q.e_dei;
    assign eg_out_rewrite = s_q.e_rewrite;
    assign eg_out_remap = s_q.e_remap;
endmodule
`default_nettype wire

// ===== iqc_properties.sv
// Purpose: port timing checks for the classifier
// Assumes: one clock domain, bound onto the top module
// Notes: apb answers after exactly one wait state
`timescale 1ns/1ns
`default_nettype none
module iqc_properties
    import iqc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // ingress side
    input wire logic in_valid,
    input wire logic in_list_hit,
    input wire logic [2:0] in_list_class,
    input wire logic in_list_dp,
    input wire logic out_valid,
    input wire logic [2:0] out_class,
    input wire logic out_dp,
    // egress side
    input wire logic eg_valid,
    input wire logic eg_out_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence apb_take;
        psel && penable && !pready;
    endsequence
    sequence bad_addr;
        paddr[11:10] != 2'h0 || paddr[9:6] >= 4'hC
            || paddr[5:0] > OFS_EMAP_HI || paddr[1:0] != 2'h0;
    endsequence
    chk_ingress_valid: assert property (
        in_valid |=> out_valid) else $error("no result for frame");
    chk_ingress_idle: assert property (
        !in_valid |=> !out_valid) else $error("result without frame");
    chk_egress_valid: assert property (
        eg_valid |=> eg_out_valid) else $error("no egress result");
    chk_list_override: assert property (
        in_valid && in_list_hit |=> out_class == $past(in_list_class)
        && out_dp == $past(in_list_dp)) else $error("list hit lost");
    chk_apb_answer: assert property (
        apb_take |=> pready) else $error("apb answer late");
    chk_ready_pulse: assert property (
        pready |=> !pready) else $error("pready held");
    chk_rdata_idle: assert property (
        !pready |-> prdata == RD_ZERO) else $error("prdata not idle");
    chk_bad_addr: assert property (
        apb_take ##0 bad_addr |=> pslverr) else $error("no error");
    chk_err_pair: assert property (
        pslverr |-> pready) else $error("error without ready");
endmodule
bind iqc_classifier iqc_properties u_chk (.*);
`default_nettype wire

// ===== iqc_frame_src.sv
// Purpose: frames and egress requests from the switch ports
// Assumes: at most one request per cycle on each side
// Notes: fields change every cycle, idle or not
`timescale 1ns/1ns
`default_nettype none
module iqc_frame_src
    import iqc_pkg::*;
(
    // clock and enable
    input wire logic clk,
    input wire logic run,
    // ingress frames
    output logic in_valid,
    output logic [3:0] in_port,
    output logic in_tagged,
    output logic [2:0] in_pcp,
    output logic in_dei,
    output logic in_is_ip,
    output logic [7:0] in_tos,
    output logic [5:0] in_dscp_xlated,
    output logic in_dscp_selected,
    output logic in_list_hit,
    output logic [2:0] in_list_class,
    output logic in_list_dp,
    // egress requests
    output logic eg_valid,
    output logic [3:0] eg_port,
    output logic [2:0] eg_class,
    output logic eg_dp,
    output logic [2:0] eg_pcp,
    output logic eg_dei
);
    int seed = 85;
    initial begin
        {in_valid, in_port, in_tagged, in_pcp, in_dei, in_is_ip} = '0;
        {in_tos, in_dscp_xlated, in_dscp_selected, in_list_hit} = '0;
        {in_list_class, in_list_dp, eg_valid, eg_port} = '0;
        {eg_class, eg_dp, eg_pcp, eg_dei} = '0;
    end
    always @(posedge clk) begin
        {in_tagged, in_pcp, in_dei, in_is_ip, in_tos} <= 14'($random(seed));
        // zero code point often, so the zero mode is seen
        in_dscp_xlated <= 6'($random(seed)) & 6'h03;
        {in_list_class, in_list_dp, in_dscp_selected} <= 5'($random(seed));
        in_list_hit <= 2'($random(seed)) == 2'h0;
        in_port <= 4'($unsigned($random(seed)) % NUM_PORTS);
        in_valid <= run & 1'($random(seed));
        {eg_class, eg_dp, eg_pcp, eg_dei} <= 8'($random(seed));
        eg_port <= 4'($unsigned($random(seed)) % NUM_PORTS);
        eg_valid <= run & 1'($random(seed));
    end
endmodule
`default_nettype wire

// ===== ingress_qos_classifier_tb.sv
// Purpose: self-checking bench for the classifier
// Assumes: random port config, random frames from the source
// Notes: expectations come from a shadow of the port config
`timescale 1ns/1ns
`default_nettype none
module ingress_qos_classifier_tb
    import iqc_pkg::*;
;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
    logic [11:0] paddr = 0, base;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, in_valid, in_tagged, in_dei, in_is_ip;
    logic [3:0] in_port, eg_port;
    logic [2:0] in_pcp, in_list_class, out_class, out_pcp, eg_class, eg_pcp;
    logic [7:0] in_tos;
    logic [5:0] in_dscp_xlated, out_dscp;
    logic in_dscp_selected, in_list_hit, in_list_dp, out_valid, out_dp;
    logic out_dei, out_dscp_classify, eg_valid, eg_dp, eg_dei, eg_out_valid;
    logic [2:0] eg_out_pcp;
    logic eg_out_dei, eg_out_rewrite;
    logic [1:0] eg_out_remap;
    logic [31:0] cfg [NUM_PORTS];
    logic [63:0] tmap [NUM_PORTS], emap [NUM_PORTS];
    logic [2:0] eff [NUM_PORTS];
    logic [11:0] bad [3] = '{12'h300, 12'h002, 12'h808};
    logic [14:0] iq [$];
    logic [6:0] eq [$];
    int seed = 85, bad_count = 0, compares = 0;
    iqc_classifier dut (.*);
    iqc_frame_src src (.*);
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task end_sim();
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [14:0] exp_in();
        logic [31:0] c;
        logic [3:0] n;
        logic [2:0] k;
        logic d, t, m;
        c = cfg[in_port];
        t = c[16] & in_tagged;
        n = tmap[in_port][{in_pcp, in_dei, 2'h0} +: 4];
        k = in_pcp == PCP_ZERO ? CLASS_OF_PCP0 : in_pcp;
        k = in_pcp == PCP_ONE ? CLASS_OF_PCP1 : k;
        k = t ? (c[8] ? n[2:0] : k) : eff[in_port];
        d = t ? (c[8] ? n[3] : in_dei) : c[3];
        k = in_list_hit ? in_list_class : k;
        d = in_list_hit ? in_list_dp : d;
        m = c[13:12] == CLS_ALL || (c[13:12] == CLS_SELECTED
            && in_dscp_selected) || (c[13:12] == CLS_ZERO
            && in_dscp_xlated == DSCP_ZERO);
        return {k, d, t ? in_pcp : c[6:4], t ? in_dei : c[7],
            m & c[9] & in_is_ip, in_tos[7:2]};
    endfunction
    function automatic logic [6:0] exp_eg();
        logic [31:0] c;
        logic [3:0] n;
        logic [1:0] r;
        c = cfg[eg_port];
        n = emap[eg_port][{eg_class, eg_dp, 2'h0} +: 4];
        r = c[15:14] == RW_REMAP_DP && eg_dp ? REMAP_DP1 : REMAP_DP0;
        r = c[15:14] < RW_REMAP ? REMAP_NONE : r;
        if (c[11:10] == RMK_DEFAULT) n = {c[7], c[6:4]};
        else if (c[11:10] != RMK_MAPPED) n = {eg_dei, eg_pcp};
        return {n[2:0], n[3], c[15:14] != RW_DISABLE, r};
    endfunction
    always @(negedge clk) begin
        if (in_valid === 1'b1) iq.push_back(exp_in());
        if (eg_valid === 1'b1) eq.push_back(exp_eg());
    end
    always @(negedge clk) begin
        if (out_valid === 1'b1) chk({out_class, out_dp, out_pcp, out_dei,
            out_dscp_classify, out_dscp}, iq.pop_front());
        if (eg_out_valid === 1'b1) chk({eg_out_pcp, eg_out_dei,
            eg_out_rewrite, eg_out_remap}, eq.pop_front());
    end
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        foreach (bad[i]) begin
            apb(1'b1, bad[i], 32'hFFFF_FFFF, rd, er);
            chk({31'h0, er}, 32'h1);
            apb(1'b0, bad[i], 32'h0, rd, er);
            chk({31'h0, er}, 32'h1);
            chk(rd, RD_ZERO);
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, rd, er);
            chk(rd, RD_ZERO);
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            // every remark, classify and rewrite mode across the ports
            cfg[p] = $random(seed) & 32'h0001_FFFF;
            cfg[p][15:10] = {2'(p / 3), 2'(p), 2'(p % 3)};
            tmap[p] = {$random(seed), $random(seed)};
            emap[p] = {$random(seed), $random(seed)};
            eff[p] = 3'($random(seed));
            base = 12'(p * 64);
            apb(1'b1, base, cfg[p], rd, er);
            apb(1'b1, base + 12'(OFS_EFF), {29'h0, eff[p]}, rd, er);
            apb(1'b1, base + 12'(OFS_TMAP_LO), tmap[p][31:0], rd, er);
            apb(1'b1, base + 12'(OFS_TMAP_HI), tmap[p][63:32], rd, er);
            apb(1'b1, base + 12'(OFS_EMAP_LO), emap[p][31:0], rd, er);
            apb(1'b1, base + 12'(OFS_EMAP_HI), emap[p][63:32], rd, er);
            apb(1'b0, base + 12'(OFS_EFF), 32'h0, rd, er);
            chk(rd, {21'h0, cfg[p][2:0], 5'h0, eff[p]});
        end
        run <= 1'b1;
        repeat (3000) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(iq.size() + eq.size()), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
